// ---- bench/cal_engine_model.sv ----
/* Calibration engine stand-in: answers each start pulse with a done level.
   Assumes start is a one-cycle pulse on the same clock. */
`timescale 1ns/1ps
`default_nettype none
module cal_engine_model #(
  parameter int CAL_CYCLES = 20
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic cal_start_i,
  output logic      cal_done_o
);
  int count_q;
  // A new start drops done at once, so a stale completion never qualifies lock.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q    <= 0;
      cal_done_o <= 1'b0;
    end else if (cal_start_i) begin
      count_q    <= CAL_CYCLES;
      cal_done_o <= 1'b0;
    end else if (count_q == 1) begin
      count_q    <= 0;
      cal_done_o <= 1'b1;
    end else if (count_q > 1) begin
      count_q <= count_q - 1;
    end
  end
endmodule : cal_engine_model
`default_nettype wire

// ---- bench/frac_divider_monitor.sv ----
/* Checker for the divider control top: bus answers, calibration start, lock and pin.
   Assumes it is bound to frac_divider_ctrl and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module frac_divider_monitor
  import frac_lock_pkg::*;
(
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [9:0]       wb_adr_i,
  input wire logic [3:0]       wb_sel_i,
  input wire logic [31:0]      wb_dat_i,
  input wire logic [31:0]      wb_dat_o,
  input wire logic             wb_ack_o,
  input wire logic             pin_mode_i,
  input wire logic             loop_locked_i,
  input wire logic             ref_present_i,
  input wire logic             cal_start_o,
  input wire logic [OUT_W-1:0] sync_extra_divide_o,
  input wire logic             multipurpose_out_pin_o,
  input wire logic             multipurpose_out_pin_oe_o,
  input wire logic             lock_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Only the low byte lane carries the enable bit, so sel[0] gates it.
  wire logic cal_wr = wb_ack_o && wb_we_i && wb_adr_i[9:2] == REG_CTRL && wb_sel_i[0]
                      && wb_dat_i[CTRL_CALEN];
  property p_ack_answer; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("ack late");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_cal_start; cal_wr |=> cal_start_o; endproperty
  a_cal_start: assert property (p_cal_start) else $error("no start pulse");
  property p_cal_cause; cal_start_o |-> $past(cal_wr); endproperty
  a_cal_cause: assert property (p_cal_cause) else $error("stray start");
  property p_lock_clear; cal_start_o |=> !lock_o [*2]; endproperty
  a_lock_clear: assert property (p_lock_clear) else $error("lock kept");
  property p_ref_loss; !ref_present_i [*4] |-> !lock_o; endproperty
  a_ref_loss: assert property (p_ref_loss) else $error("lock without ref");
  property p_loop_loss; !loop_locked_i [*4] |-> !lock_o; endproperty
  a_loop_loss: assert property (p_loop_loss) else $error("lock without loop");
  property p_rb_first;
    wb_ack_o && !wb_we_i && !pin_mode_i |=> multipurpose_out_pin_oe_o
      && multipurpose_out_pin_o == $past(wb_dat_o[31]);
  endproperty
  a_rb_first: assert property (p_rb_first) else $error("readback msb wrong");
  property p_pin_mode; pin_mode_i [*4] |-> multipurpose_out_pin_oe_o; endproperty
  a_pin_mode: assert property (p_pin_mode) else $error("pin mode not driving");
  // The checker sees sync mode only through bus writes, so it keeps its own copy.
  logic sync_mode_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_mode_q <= MOD_CFG_RST[MCFG_SYNC];
    end else if (wb_ack_o && wb_we_i && wb_adr_i[9:2] == REG_MOD_CFG && wb_sel_i[2]) begin
      sync_mode_q <= wb_dat_i[MCFG_SYNC];
    end
  end
  property p_extra_div;
    sync_extra_divide_o != '0 && (sync_mode_q || sync_extra_divide_o == 8'h01);
  endproperty
  a_extra_div: assert property (p_extra_div) else $error("extra divide zero");
endmodule : frac_divider_monitor
bind frac_divider_ctrl frac_divider_monitor mon (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .pin_mode_i(pin_mode_i), .loop_locked_i(loop_locked_i), .ref_present_i(ref_present_i),
  .cal_start_o(cal_start_o), .sync_extra_divide_o(sync_extra_divide_o),
  .multipurpose_out_pin_o(multipurpose_out_pin_o),
  .multipurpose_out_pin_oe_o(multipurpose_out_pin_oe_o), .lock_o(lock_o));
`default_nettype wire

// ---- bench/tb_top.sv ----
/* Self-checking bench for frac_divider_ctrl over classic Wishbone.
   Assumes the calibration model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import frac_lock_pkg::*;
;
  logic             clk_i, rst_i, cyc, stb, we, ack, pin_mode, cal_done, cal_start;
  logic             vtune_ok, loop_ok, ref_ok, pin, pin_oe, lock;
  logic [9:0]       adr;
  logic [3:0]       sel;
  logic [31:0]      dat_w, dat_r;
  logic [INT_W-1:0] pin_n;
  logic [INT_W:0]   ratio;
  logic [OUT_W-1:0] extra;
  logic [2:0]       dly_sel;
  int               errors, comparisons, cycles;

  frac_divider_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
    .wb_ack_o(ack), .pin_mode_i(pin_mode), .pin_int_n_i(pin_n), .cal_done_i(cal_done),
    .vtune_ok_i(vtune_ok), .loop_locked_i(loop_ok), .ref_present_i(ref_ok),
    .cal_start_o(cal_start), .feedback_ratio_o(ratio), .sync_extra_divide_o(extra),
    .detector_delay_select_o(dly_sel), .multipurpose_out_pin_o(pin),
    .multipurpose_out_pin_oe_o(pin_oe), .lock_o(lock));
  cal_engine_model partner (.clk_i(clk_i), .rst_i(rst_i), .cal_start_i(cal_start),
    .cal_done_o(cal_done));

  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 10000) begin
      errors++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Outputs are read in the edge's active region, before the registers update.
  task automatic wb(input logic w, input logic [7:0] idx, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= 4'hF;
    dat_w <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, idx, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, idx, '0, q);
    check(q, exp);
  endtask : rd
  task automatic measure(output longint s);
    s = 0;
    // The value launched on the clear edge still belongs to the old state.
    @(posedge clk_i);
    repeat (256) begin
      @(posedge clk_i);
      s += ratio;
    end
  endtask : measure
  task automatic finish_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  initial begin
    static logic [7:0]  idx [9] = '{REG_CTRL, REG_LOCK_TYPE, REG_LOCK_DLY, REG_INT_N,
                                    REG_FRAC_DEN, REG_FRAC_NUM, REG_MOD_CFG, REG_STATUS, 8'h10};
    static logic [31:0] rv [9] = '{CTRL_RST, LOCK_TYPE_RST, LOCK_DLY_RST, INT_N_RST,
                                   FRAC_DEN_RST, FRAC_NUM_RST, MOD_CFG_RST, 32'h0, 32'h0};
    static logic [31:0] nums [5] = '{1, 1, 1, 3, 32'h8000_0000};
    static logic [31:0] dens [5] = '{2, 2, 3, 4, 32'hFFFF_FFFF};
    logic [31:0] q, v;
    logic        ok;
    longint      s1, s2, e;
    int          n;
    {clk_i, cyc, stb, we, pin_mode, vtune_ok, adr, sel, dat_w} = '0;
    {rst_i, loop_ok, ref_ok} = 3'b111;
    pin_n = 19'd40;
    {errors, comparisons, cycles} = '0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    check({31'd0, pin_oe}, 32'd0);
    for (int i = 0; i < 9; i++) rd(idx[i], rv[i]);
    wr(REG_STATUS, 32'hFFFF_FFFF);
    rd(REG_STATUS, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      wr(REG_INT_N, 32'd60);
      wr(REG_FRAC_NUM, nums[i]);
      wr(REG_FRAC_DEN, dens[i]);
      wr(REG_MOD_CFG, 32'(i) | (32'(i + 1) << 4) | 32'h100);
      wr(REG_CTRL, CTRL_RST);
      measure(s1);
      wr(REG_CTRL, CTRL_RST);
      measure(s2);
      e = (i == 0) ? 15360 : 15360 + (256 * longint'(nums[i])) / longint'(dens[i]);
      check({31'd0, s1 >= e - 16 * i && s1 <= e + 16 * i}, 32'd1);
      check(s1[31:0], s2[31:0]);
      check({29'd0, dly_sel}, 32'(i + 1));
    end
    wr(REG_MOD_CFG, 32'h0000_0310);
    @(posedge clk_i);
    check({24'd0, extra}, 32'd1);
    wr(REG_MOD_CFG, 32'h0001_0310);
    @(posedge clk_i);
    check({24'd0, extra}, 32'd3);
    $display("test modulator done");
    wr(REG_LOCK_DLY, 32'd5);
    wr(REG_CTRL, 32'h0000_0008);
    n = 0;
    while (lock !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    check({31'd0, n >= 25 && n <= 40}, 32'd1);
    repeat (2) @(posedge clk_i);
    check({30'd0, pin_oe, pin}, 32'd3);
    rd(REG_STATUS, 32'h0000_0200);
    repeat (34) @(posedge clk_i);
    ref_ok <= 1'b0;
    repeat (6) @(posedge clk_i);
    check({30'd0, lock, pin}, 32'd0);
    ref_ok <= 1'b1;
    repeat (6) @(posedge clk_i);
    check({31'd0, lock}, 32'd1);
    loop_ok <= 1'b0;
    repeat (6) @(posedge clk_i);
    check({30'd0, lock, pin}, 32'd0);
    loop_ok <= 1'b1;
    wr(REG_LOCK_TYPE, 32'd1);
    wr(REG_CTRL, 32'h0000_0008);
    repeat (60) @(posedge clk_i);
    check({31'd0, lock}, 32'd0);
    vtune_ok <= 1'b1;
    repeat (8) @(posedge clk_i);
    check({31'd0, lock}, 32'd1);
    $display("test lock done");
    wr(REG_CTRL, CTRL_RST);
    wb(1'b0, REG_INT_N, '0, q);
    v = '0;
    ok = 1'b1;
    repeat (32) begin
      @(posedge clk_i);
      v = {v[30:0], pin};
      ok &= pin_oe;
    end
    check(v, 32'd60);
    check({31'd0, ok}, 32'd1);
    repeat (3) @(posedge clk_i);
    check({31'd0, pin_oe}, 32'd0);
    pin_mode <= 1'b1;
    repeat (10) @(posedge clk_i);
    check({12'd0, ratio}, 32'd40);
    check({30'd0, pin_oe, pin}, {30'd0, 1'b1, lock});
    $display("test pins done");
    finish_test();
  end
endmodule : tb_top
`default_nettype wire

// ---- core/frac_divider_ctrl.sv ----
/*
 * Top of the feedback divider control: Wishbone register slave, modulator,
 * calibration handshake, lock qualification and the multipurpose output pin.
 * Assumes clk_i is the detector-rate system clock and that pins are asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none
module frac_divider_ctrl
  import frac_lock_pkg::*;
#(
  parameter int PD_DIV = 1
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [9:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              pin_mode_i,
  input  wire logic [INT_W-1:0]  pin_int_n_i,
  input  wire logic              cal_done_i,
  input  wire logic              vtune_ok_i,
  input  wire logic              loop_locked_i,
  input  wire logic              ref_present_i,
  output logic                   cal_start_o,
  output logic      [INT_W:0]    feedback_ratio_o,
  output logic      [OUT_W-1:0]  sync_extra_divide_o,
  output logic      [2:0]        detector_delay_select_o,
  output logic                   multipurpose_out_pin_o,
  output logic                   multipurpose_out_pin_oe_o,
  output logic                   lock_o
);
  localparam int SYNC_W = INT_W + 5;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic [SYNC_W-1:0] meta_q;
  logic [SYNC_W-1:0] sync_q;
  logic              pin_mode_s;
  logic [INT_W-1:0]  pin_int_n_s;
  logic              cal_done_s;
  logic              vtune_ok_s;
  logic              loop_locked_s;
  logic              ref_present_s;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= {pin_mode_i, pin_int_n_i, cal_done_i, vtune_ok_i, loop_locked_i,
                 ref_present_i};
      sync_q <= meta_q;
    end
  end

  assign {pin_mode_s, pin_int_n_s, cal_done_s, vtune_ok_s, loop_locked_s,
          ref_present_s} = sync_q;

  ////////////////////////////////////////////////////////////////////////////
  // Detector-rate tick.

  logic [15:0] div_q;
  logic        tick;

  assign tick = (div_q == 16'(PD_DIV - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave. Ack follows a request by one cycle; the write lands on the
  // edge that also sees ack high, so the master and the registers agree.

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  logic [7:0]  idx;
  logic        req;
  logic        wr_en;
  logic        rd_take;
  logic        wr_ctrl;
  logic        wr_type;
  logic        wr_dly;
  logic        wr_int;
  logic        wr_den;
  logic        wr_num;
  logic        wr_mcfg;
  logic [31:0] rd_word;
  logic        ack_q;
  logic [31:0] dat_q;

  assign idx     = wb_adr_i[9:2];
  assign req     = wb_cyc_i && wb_stb_i;
  assign wr_en   = req && wb_we_i && ack_q;
  assign rd_take = req && !wb_we_i && !ack_q;
  assign wr_ctrl = wr_en && (idx == REG_CTRL);
  assign wr_type = wr_en && (idx == REG_LOCK_TYPE);
  assign wr_dly  = wr_en && (idx == REG_LOCK_DLY);
  assign wr_int  = wr_en && (idx == REG_INT_N);
  assign wr_den  = wr_en && (idx == REG_FRAC_DEN);
  assign wr_num  = wr_en && (idx == REG_FRAC_NUM);
  assign wr_mcfg = wr_en && (idx == REG_MOD_CFG);

  logic [31:0] ctrl_q;
  logic [31:0] type_q;
  logic [31:0] dly_q;
  logic [31:0] int_q;
  logic [31:0] den_q;
  logic [31:0] num_q;
  logic [31:0] mcfg_q;
  logic [31:0] status_word;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RST;
      type_q <= LOCK_TYPE_RST;
      dly_q  <= LOCK_DLY_RST;
      int_q  <= INT_N_RST;
      den_q  <= FRAC_DEN_RST;
      num_q  <= FRAC_NUM_RST;
      mcfg_q <= MOD_CFG_RST;
    end else begin
      if (wr_ctrl) ctrl_q <= merge(ctrl_q, wb_dat_i, wb_sel_i) & 32'h0000_000C;
      if (wr_type) type_q <= merge(type_q, wb_dat_i, wb_sel_i) & 32'h0000_0001;
      if (wr_dly)  dly_q  <= merge(dly_q, wb_dat_i, wb_sel_i) & 32'h0000_FFFF;
      if (wr_int)  int_q  <= merge(int_q, wb_dat_i, wb_sel_i) & 32'h0007_FFFF;
      if (wr_den)  den_q  <= merge(den_q, wb_dat_i, wb_sel_i);
      if (wr_num)  num_q  <= merge(num_q, wb_dat_i, wb_sel_i);
      if (wr_mcfg) mcfg_q <= merge(mcfg_q, wb_dat_i, wb_sel_i) & 32'h0001_FF77;
    end
  end

  always_comb begin
    case (idx)
      REG_CTRL:      rd_word = ctrl_q;
      REG_LOCK_TYPE: rd_word = type_q;
      REG_LOCK_DLY:  rd_word = dly_q;
      REG_INT_N:     rd_word = int_q;
      REG_FRAC_DEN:  rd_word = den_q;
      REG_FRAC_NUM:  rd_word = num_q;
      REG_MOD_CFG:   rd_word = mcfg_q;
      REG_STATUS:    rd_word = status_word;
      default:       rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end else begin
      ack_q <= req && !ack_q;
      if (rd_take) begin
        dat_q <= rd_word;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  ////////////////////////////////////////////////////////////////////////////
  // Calibration handshake. A start is a one-cycle pulse; completion is the
  // first synchronised done level seen after done has been seen low in this run.

  logic [31:0] ctrl_next;
  logic        cal_go;
  logic        cal_busy_q;
  logic        cal_armed_q;
  logic        cal_complete_q;
  logic        cal_start_q;

  assign ctrl_next = merge(ctrl_q, wb_dat_i, wb_sel_i);
  assign cal_go    = wr_ctrl && ctrl_next[CTRL_CALEN];

  // Done must be seen low before it counts, so a level left over from the last
  // run cannot end this one; an engine that never drops done would hang here.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cal_busy_q     <= 1'b0;
      cal_armed_q    <= 1'b0;
      cal_complete_q <= 1'b0;
      cal_start_q    <= 1'b0;
    end else begin
      cal_start_q <= cal_go;
      if (cal_go) begin
        cal_busy_q     <= 1'b1;
        cal_armed_q    <= 1'b0;
        cal_complete_q <= 1'b0;
      end else if (cal_busy_q && !cal_armed_q && !cal_done_s) begin
        cal_armed_q <= 1'b1;
      end else if (cal_busy_q && cal_armed_q && cal_done_s) begin
        cal_busy_q     <= 1'b0;
        cal_complete_q <= 1'b1;
      end
    end
  end

  assign cal_start_o = cal_start_q;

  ////////////////////////////////////////////////////////////////////////////
  // Divider settings. Pin mode forces integer division from the strap pins.

  logic             spi_mode;
  logic [2:0]       order_eff;
  logic [INT_W-1:0] int_eff;
  logic [OUT_W-1:0] extra_cfg;
  logic [2:0]       order_cfg;

  assign spi_mode  = !pin_mode_s;
  assign order_cfg = (mcfg_q[MCFG_ORDER_LSB +: 3] > 3'(MOD_MAX_ORDER)) ?
                     3'(MOD_MAX_ORDER) : mcfg_q[MCFG_ORDER_LSB +: 3];
  assign order_eff = spi_mode ? order_cfg : 3'd0;
  assign int_eff   = spi_mode ? int_q[INT_W-1:0] : pin_int_n_s;
  assign extra_cfg = mcfg_q[MCFG_EXTRA_LSB +: OUT_W];

  // Values below one make no sense as a divide factor, so they read as one.
  assign sync_extra_divide_o = (mcfg_q[MCFG_SYNC] && extra_cfg > 8'h01) ?
                               extra_cfg : 8'h01;
  // The host must pick the delay and minimum integer value; nothing is checked.
  assign detector_delay_select_o = mcfg_q[MCFG_DLYSEL_LSB +: 3];

  sd_modulator u_mod (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .clear_i (wr_ctrl),
    .step_i  (tick),
    .order_i (order_eff),
    .int_i   (int_eff),
    .num_i   (num_q),
    .den_i   (den_q),
    .ratio_o (feedback_ratio_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Lock qualification and status.

  logic lock_type;

  assign lock_type = type_q[LOCK_TYPE_BIT];

  lock_qualifier u_lock (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .tick_i         (tick),
    .cal_start_i    (cal_go),
    .cal_complete_i (cal_complete_q),
    .vtune_ok_i     (vtune_ok_s),
    .loop_locked_i  (loop_locked_s),
    .ref_present_i  (ref_present_s),
    .type_i         (lock_type),
    .delay_i        (dly_q[DLY_W-1:0]),
    .lock_o         (lock_o)
  );

  assign status_word = {21'd0, vtune_ok_s, lock_o, 9'd0};

  ////////////////////////////////////////////////////////////////////////////
  // Readback shifter. A register read in serial mode sends the word MSB
  // first, one bit a cycle; the pin is owned by readback for those 32 cycles.

  logic [31:0] shift_q;
  logic [5:0]  shift_cnt_q;
  logic        rb_active;

  assign rb_active = (shift_cnt_q != 6'd0);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shift_q     <= '0;
      shift_cnt_q <= '0;
    end else if (rd_take && spi_mode) begin
      shift_q     <= rd_word;
      shift_cnt_q <= 6'd32;
    end else if (rb_active) begin
      shift_q     <= {shift_q[30:0], 1'b0};
      shift_cnt_q <= shift_cnt_q - 6'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Multipurpose pin selection.

  logic outpin_select_bit;
  logic pin_data_d;
  logic pin_oe_d;
  logic pin_data_q;
  logic pin_oe_q;

  assign outpin_select_bit = ctrl_q[CTRL_OUTSEL];

  always_comb begin
    if (!spi_mode) begin
      pin_oe_d   = 1'b1;
      pin_data_d = lock_o;
    end else if (rb_active) begin
      pin_oe_d   = 1'b1;
      pin_data_d = shift_q[31];
    end else begin
      pin_oe_d   = !outpin_select_bit;
      pin_data_d = !outpin_select_bit && lock_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_data_q <= 1'b0;
      pin_oe_q   <= 1'b0;
    end else begin
      pin_data_q <= pin_data_d;
      pin_oe_q   <= pin_oe_d;
    end
  end

  assign multipurpose_out_pin_o    = pin_data_q;
  assign multipurpose_out_pin_oe_o = pin_oe_q;
endmodule : frac_divider_ctrl
`default_nettype wire

// ---- core/frac_lock_pkg.sv ----
/*
 * Shared constants for the fractional feedback divider and lock-detect block:
 * register indices, field positions, reset values and widths.
 * Assumes a 32-bit classic Wishbone bus; byte address is four times the index.
 */
package frac_lock_pkg;
  localparam int          INT_W          = 19;
  localparam int          FRAC_W         = 32;
  localparam int          DLY_W          = 16;
  localparam int          MOD_MAX_ORDER  = 4;
  localparam int          OUT_W          = 8;

  localparam logic [7:0]  REG_CTRL       = 8'h00;
  localparam logic [7:0]  REG_LOCK_TYPE  = 8'h3B;
  localparam logic [7:0]  REG_LOCK_DLY   = 8'h3C;
  localparam logic [7:0]  REG_STATUS     = 8'h6E;
  localparam logic [7:0]  REG_INT_N      = 8'h24;
  localparam logic [7:0]  REG_FRAC_DEN   = 8'h26;
  localparam logic [7:0]  REG_FRAC_NUM   = 8'h2A;
  localparam logic [7:0]  REG_MOD_CFG    = 8'h2C;

  localparam int          CTRL_OUTSEL    = 2;
  localparam int          CTRL_CALEN     = 3;
  localparam int          LOCK_TYPE_BIT  = 0;
  localparam int          STAT_LOCK      = 9;
  localparam int          STAT_VTUNE     = 10;
  localparam int          MCFG_ORDER_LSB = 0;
  localparam int          MCFG_DLYSEL_LSB = 4;
  localparam int          MCFG_EXTRA_LSB = 8;
  localparam int          MCFG_SYNC      = 16;

  localparam logic [31:0] CTRL_RST       = 32'h0000_0004;
  localparam logic [31:0] LOCK_TYPE_RST  = 32'h0000_0000;
  localparam logic [31:0] LOCK_DLY_RST   = 32'h0000_0000;
  localparam logic [31:0] INT_N_RST      = 32'h0000_0064;
  localparam logic [31:0] FRAC_DEN_RST   = 32'h0000_0001;
  localparam logic [31:0] FRAC_NUM_RST   = 32'h0000_0000;
  localparam logic [31:0] MOD_CFG_RST    = 32'h0000_0110;
endpackage : frac_lock_pkg

// ---- core/lock_qualifier.sv ----
/*
 * Lock qualification: delay counter after calibration and indicator type selection.
 * Assumes all status inputs are already synchronised to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module lock_qualifier
  import frac_lock_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             tick_i,
  input  wire logic             cal_start_i,
  input  wire logic             cal_complete_i,
  input  wire logic             vtune_ok_i,
  input  wire logic             loop_locked_i,
  input  wire logic             ref_present_i,
  input  wire logic             type_i,
  input  wire logic [DLY_W-1:0] delay_i,
  output logic                  lock_o
);
  logic [DLY_W-1:0] cnt_q;
  logic             expired;
  logic             qualified;

  assign expired = cal_complete_i && (cnt_q >= delay_i);
  // Type 0 ignores the tuning voltage; type 1 requires it inside limits.
  assign qualified = expired && (!type_i || vtune_ok_i)
                     && loop_locked_i && ref_present_i;

  always_ff @(posedge clk_i) begin
    if (rst_i || cal_start_i) begin
      cnt_q <= '0;
    end else if (tick_i && cal_complete_i && cnt_q < delay_i) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || cal_start_i) begin
      lock_o <= 1'b0;
    end else begin
      lock_o <= qualified;
    end
  end
endmodule : lock_qualifier
`default_nettype wire

// ---- core/sd_modulator.sv ----
/*
 * Cascaded-accumulator sigma-delta modulator of order 0 to 4.
 * Assumes a one-cycle step enable at the phase detector rate and a same-clock reset pulse.
 */
`timescale 1ns/1ps
`default_nettype none
module sd_modulator
  import frac_lock_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              clear_i,
  input  wire logic              step_i,
  input  wire logic [2:0]        order_i,
  input  wire logic [INT_W-1:0]  int_i,
  input  wire logic [FRAC_W-1:0] num_i,
  input  wire logic [FRAC_W-1:0] den_i,
  output logic      [INT_W:0]    ratio_o
);
  logic [FRAC_W-1:0] acc_q [MOD_MAX_ORDER];
  logic [FRAC_W-1:0] acc_d [MOD_MAX_ORDER];
  logic              carry [MOD_MAX_ORDER];
  logic signed [5:0] diff_q [MOD_MAX_ORDER];
  logic signed [5:0] diff_d [MOD_MAX_ORDER+1];
  logic              frac_on;

  // A zero denominator has no meaning, so it falls back to integer division.
  assign frac_on = (order_i != 3'd0) && (den_i != '0);
  assign diff_d[MOD_MAX_ORDER] = 6'sd0;

  genvar g;
  generate
    for (g = 0; g < MOD_MAX_ORDER; g++) begin : g_stage
      logic [FRAC_W:0]   sum;
      logic [FRAC_W-1:0] addend;
      logic              live;
      if (g == 0) begin : g_first
        assign addend = num_i;
      end else begin : g_next
        assign addend = acc_d[g-1];
      end
      assign live  = frac_on && (g < order_i);
      assign sum   = {1'b0, acc_q[g]} + {1'b0, addend};
      assign carry[g] = live && (sum >= {1'b0, den_i});
      assign acc_d[g] = !live ? '0 : carry[g] ? FRAC_W'(sum - {1'b0, den_i}) : sum[FRAC_W-1:0];
      assign diff_d[g] = $signed({5'd0, carry[g]}) + diff_d[g+1] - diff_q[g];
      always_ff @(posedge clk_i) begin
        if (rst_i || clear_i) begin
          acc_q[g]  <= '0;
          diff_q[g] <= 6'sd0;
        end else if (step_i) begin
          acc_q[g]  <= acc_d[g];
          diff_q[g] <= diff_d[g+1];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ratio_o <= '0;
    end else if (step_i) begin
      ratio_o <= (INT_W+1)'($signed({1'b0, int_i}) + diff_d[0]);
    end
  end
endmodule : sd_modulator
`default_nettype wire
